//--- verilog/sscb_map.svh
// Register offsets, field positions, reset values and timing figures of the
// socket system control block. Assumes a 20 MHz aclk and byte addressing.
`ifndef SSCB_MAP_SVH
`define SSCB_MAP_SVH

// -----------------------------------------------------------------------
// Offsets
// -----------------------------------------------------------------------
`define SSCB_SYSCTL_OFS 8'h80
`define SSCB_INT_STATUS_OFS 8'h90
`define SSCB_INT_ENABLE_OFS 8'h94
`define SSCB_INT_CLEAR_OFS 8'h98

// -----------------------------------------------------------------------
// Field positions of system_level_control
// -----------------------------------------------------------------------
`define SSCB_TERM_DRIVE_BIT 22
`define SSCB_SUPPLY_PROT_BIT 21
`define SSCB_RSVD_FIELD_HI 20
`define SSCB_RSVD_FIELD_LO 16
`define SSCB_BURST_CARD_BIT 15
`define SSCB_BURST_HOST_BIT 14
`define SSCB_ACTIVITY_BIT 13
`define SSCB_ONE_BIT 12
`define SSCB_STREAM_BUSY_BIT 11
`define SSCB_UP_SETTLE_BIT 10
`define SSCB_DOWN_SETTLE_BIT 9
`define SSCB_INTERROG_BIT 8
`define SSCB_ZERO_BIT 7
`define SSCB_LOW_POWER_BIT 6
`define SSCB_ID_LOCK_BIT 5

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define SSCB_RSVD_FIELD_RST 5'h04
`define SSCB_INT_ENABLE_RST 3'h0

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define SSCB_CLK_PERIOD_NS 50
`define SSCB_UP_DELAY_NS 50000
`define SSCB_DOWN_DELAY_NS 100000

`endif

//--- verilog/sscb_pkg.sv
// Types shared by the socket system control block.
// Assumes sscb_map.svh supplies all numeric constants.
package sscb_pkg;

	// Control fields that leave the register bank as one bundle.
	typedef struct packed {
		logic reserved_terminal_drive;
		logic supply_protect_disable;
		logic [4:0] rsvd_field;
		logic read_burst_toward_card;
		logic read_burst_toward_host;
		logic low_power_enable;
		logic id_write_lock;
	} sscb_ctl_s;

	// Interrupt sources, one sticky status bit each.
	typedef struct packed {
		logic interrog_done;
		logic stream_done;
		logic activity;
	} sscb_evt_s;

endpackage

//--- verilog/sscb_settle.sv
// Settling delay timer: busy from a start pulse until DELAY_CYCLES expire.
// Assumes start is a one-cycle pulse on aclk; clr drops it at once.
`timescale 1ns/1ps
module sscb_settle #(
	parameter int DELAY_CYCLES = 1000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic start,
	output logic busy_q
);
	logic [15:0] cnt_q;

	initial begin
		if (DELAY_CYCLES < 1 || DELAY_CYCLES > 65535) begin
			$error("sscb_settle: DELAY_CYCLES out of range");
		end
	end

	// A fresh start restarts the whole delay, so a late command is never cut short.
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			busy_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (start) begin
			busy_q <= 1'b1;
			cnt_q <= 16'(DELAY_CYCLES - 1);
		end else if (busy_q) begin
			if (cnt_q == 16'h0000) begin
				busy_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end
endmodule // sscb_settle

//--- verilog/sscb_axil.sv
// AXI4-Lite slave front end: one write and one read in flight at a time.
// Assumes the register bank answers hit flags and read data combinationally.
`timescale 1ns/1ps
module sscb_axil #(
	parameter int AW = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AW-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [AW-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	output logic wr_req,
	output logic [AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	output logic rd_req,
	input wire logic rd_hit,
	input wire logic [31:0] rd_data
);
	logic aw_have_q;
	logic w_have_q;

	assign s_axil_awready = !aw_have_q && !s_axil_bvalid;
	assign s_axil_wready = !w_have_q && !s_axil_bvalid;
	assign wr_req = aw_have_q && w_have_q;
	assign s_axil_arready = !s_axil_rvalid;
	assign rd_req = s_axil_arvalid && s_axil_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			wr_addr <= '0;
		end else if (s_axil_awvalid && s_axil_awready) begin
			aw_have_q <= 1'b1;
			wr_addr <= s_axil_awaddr;
		end else if (wr_req) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else if (s_axil_wvalid && s_axil_wready) begin
			w_have_q <= 1'b1;
			wr_data <= s_axil_wdata;
			wr_strb <= s_axil_wstrb;
		end else if (wr_req) begin
			w_have_q <= 1'b0;
		end
	end

	// Unmapped addresses answer DECERR so software sees the miss.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= 2'h0;
		end else if (wr_req) begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp <= wr_hit ? 2'h0 : 2'h3;
		end else if (s_axil_bready) begin
			s_axil_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= 32'h0000_0000;
			s_axil_rresp <= 2'h0;
		end else if (rd_req) begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata <= rd_hit ? rd_data : 32'h0000_0000;
			s_axil_rresp <= rd_hit ? 2'h0 : 2'h3;
		end else if (s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
	end
endmodule // sscb_axil

//--- verilog/sscb_ctrl.sv
// Socket system control bank: bits 22..5 of system_level_control plus a
// small interrupt block, reached over AXI4-Lite.
// Assumes one 20 MHz clock, synchronous resets and inputs already on aclk.
`timescale 1ns/1ps
`include "sscb_map.svh"

module sscb_ctrl #(
	parameter int AW = 8,
	parameter int UP_DELAY_CYCLES =
		(`SSCB_UP_DELAY_NS + `SSCB_CLK_PERIOD_NS - 1) / `SSCB_CLK_PERIOD_NS,
	parameter int DOWN_DELAY_CYCLES =
		(`SSCB_DOWN_DELAY_NS + `SSCB_CLK_PERIOD_NS - 1) / `SSCB_CLK_PERIOD_NS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bus_reset_n,
	input wire logic pme_enable,
	input wire logic [AW-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [AW-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic card_access,
	input wire logic card32_present,
	input wire logic pwr_stream_active,
	input wire logic pwr_sent_up,
	input wire logic pwr_sent_down,
	input wire logic interrogate_active,
	output sscb_pkg::sscb_ctl_s ctl_q,
	output logic rsvd_term_out,
	output logic rsvd_term_oe_n_q,
	output logic irq_q
);
	// -----------------------------------------------------------------------
	// Elaboration checks
	// -----------------------------------------------------------------------
	initial begin
		if (AW < 8 || AW > 32) begin
			$error("sscb_ctrl: AW must lie in 8..32");
		end
	end

	// -----------------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------------
	logic wr_req;
	logic [AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	logic rd_req;
	logic rd_hit;
	logic [31:0] rd_data;
	logic wr_sys;
	logic rd_sys;
	logic activity_q;
	logic stream_busy_q;
	logic up_busy;
	logic down_busy;
	logic interrog_q;
	logic ctx_clr;
	logic [31:0] sys_word;
	logic [31:0] sys_new;
	sscb_pkg::sscb_evt_s evt;
	sscb_pkg::sscb_evt_s status_q;
	sscb_pkg::sscb_evt_s enable_q;
	sscb_pkg::sscb_evt_s clear_w;

	// -----------------------------------------------------------------------
	// Functions
	// -----------------------------------------------------------------------
	function automatic logic is_ofs(input logic [AW-1:0] a, input logic [7:0] ofs);
		is_ofs = (a == AW'(ofs));
	endfunction

	// Byte lanes without a strobe keep their old contents.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// -----------------------------------------------------------------------
	// Bus front end and decode
	// -----------------------------------------------------------------------
	sscb_axil #(
		.AW(AW)
	) u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid),
		.s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata),
		.s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid),
		.s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp),
		.s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready),
		.s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid),
		.s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata),
		.s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid),
		.s_axil_rready(s_axil_rready),
		.wr_req(wr_req),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_req(rd_req),
		.rd_hit(rd_hit),
		.rd_data(rd_data)
	);

	assign wr_hit = is_ofs(wr_addr, `SSCB_SYSCTL_OFS) ||
		is_ofs(wr_addr, `SSCB_INT_ENABLE_OFS) ||
		is_ofs(wr_addr, `SSCB_INT_CLEAR_OFS);
	assign rd_hit = is_ofs(s_axil_araddr, `SSCB_SYSCTL_OFS) ||
		is_ofs(s_axil_araddr, `SSCB_INT_STATUS_OFS) ||
		is_ofs(s_axil_araddr, `SSCB_INT_ENABLE_OFS) ||
		is_ofs(s_axil_araddr, `SSCB_INT_CLEAR_OFS);
	assign wr_sys = wr_req && is_ofs(wr_addr, `SSCB_SYSCTL_OFS);
	assign rd_sys = rd_req && is_ofs(s_axil_araddr, `SSCB_SYSCTL_OFS);

	// -----------------------------------------------------------------------
	// Read data
	// -----------------------------------------------------------------------
	always_comb begin
		sys_word = 32'h0000_0000;
		sys_word[`SSCB_TERM_DRIVE_BIT] = ctl_q.reserved_terminal_drive;
		sys_word[`SSCB_SUPPLY_PROT_BIT] = ctl_q.supply_protect_disable;
		sys_word[`SSCB_RSVD_FIELD_HI:`SSCB_RSVD_FIELD_LO] = ctl_q.rsvd_field;
		sys_word[`SSCB_BURST_CARD_BIT] = ctl_q.read_burst_toward_card;
		sys_word[`SSCB_BURST_HOST_BIT] = ctl_q.read_burst_toward_host;
		sys_word[`SSCB_ACTIVITY_BIT] = activity_q;
		sys_word[`SSCB_ONE_BIT] = 1'b1;
		sys_word[`SSCB_STREAM_BUSY_BIT] = stream_busy_q;
		sys_word[`SSCB_UP_SETTLE_BIT] = up_busy;
		sys_word[`SSCB_DOWN_SETTLE_BIT] = down_busy;
		sys_word[`SSCB_INTERROG_BIT] = interrog_q;
		sys_word[`SSCB_ZERO_BIT] = 1'b0;
		sys_word[`SSCB_LOW_POWER_BIT] = ctl_q.low_power_enable;
		sys_word[`SSCB_ID_LOCK_BIT] = ctl_q.id_write_lock;
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		if (is_ofs(s_axil_araddr, `SSCB_SYSCTL_OFS)) begin
			rd_data = sys_word;
		end else if (is_ofs(s_axil_araddr, `SSCB_INT_STATUS_OFS)) begin
			rd_data[2:0] = status_q;
		end else if (is_ofs(s_axil_araddr, `SSCB_INT_ENABLE_OFS)) begin
			rd_data[2:0] = enable_q;
		end
	end

	// -----------------------------------------------------------------------
	// Control fields
	// -----------------------------------------------------------------------
	assign sys_new = merge(sys_word, wr_data, wr_strb);

	// Only the global reset restores these; the bus reset is not looked at.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q.reserved_terminal_drive <= 1'b1;
			ctl_q.supply_protect_disable <= 1'b0;
			ctl_q.rsvd_field <= `SSCB_RSVD_FIELD_RST;
			ctl_q.read_burst_toward_card <= 1'b1;
			ctl_q.read_burst_toward_host <= 1'b0;
			ctl_q.low_power_enable <= 1'b1;
			ctl_q.id_write_lock <= 1'b1;
		end else if (wr_sys) begin
			ctl_q.reserved_terminal_drive <= sys_new[`SSCB_TERM_DRIVE_BIT];
			ctl_q.supply_protect_disable <= sys_new[`SSCB_SUPPLY_PROT_BIT];
			// Stored as written; software is trusted to write back what it read.
			ctl_q.rsvd_field <= sys_new[`SSCB_RSVD_FIELD_HI:`SSCB_RSVD_FIELD_LO];
			ctl_q.read_burst_toward_card <= sys_new[`SSCB_BURST_CARD_BIT];
			ctl_q.read_burst_toward_host <= sys_new[`SSCB_BURST_HOST_BIT];
			ctl_q.low_power_enable <= sys_new[`SSCB_LOW_POWER_BIT];
			ctl_q.id_write_lock <= sys_new[`SSCB_ID_LOCK_BIT];
		end
	end

	// The terminals are only ever pulled low, never driven high.
	assign rsvd_term_out = 1'b0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsvd_term_oe_n_q <= 1'b1;
		end else begin
			rsvd_term_oe_n_q <= !(ctl_q.reserved_terminal_drive && card32_present);
		end
	end

	// -----------------------------------------------------------------------
	// Status bits
	// -----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			activity_q <= 1'b0;
		end else if (card_access) begin
			activity_q <= 1'b1;
		end else if (rd_sys) begin
			activity_q <= 1'b0;
		end
	end

	// With power events enabled the context bits survive a bus reset.
	assign ctx_clr = !bus_reset_n && !pme_enable;

	sscb_settle #(
		.DELAY_CYCLES(UP_DELAY_CYCLES)
	) u_up_settle (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(ctx_clr),
		.start(pwr_sent_up),
		.busy_q(up_busy)
	);

	sscb_settle #(
		.DELAY_CYCLES(DOWN_DELAY_CYCLES)
	) u_down_settle (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(ctx_clr),
		.start(pwr_sent_down),
		.busy_q(down_busy)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stream_busy_q <= 1'b0;
		end else begin
			stream_busy_q <= pwr_stream_active || pwr_sent_up || pwr_sent_down ||
				up_busy || down_busy;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || ctx_clr) begin
			interrog_q <= 1'b0;
		end else begin
			interrog_q <= interrogate_active;
		end
	end

	// -----------------------------------------------------------------------
	// Interrupts
	// -----------------------------------------------------------------------
	assign evt.activity = card_access;
	assign evt.stream_done = stream_busy_q && !(pwr_stream_active || pwr_sent_up ||
		pwr_sent_down || up_busy || down_busy);
	assign evt.interrog_done = interrog_q && !interrogate_active && !ctx_clr;
	assign clear_w = (wr_req && is_ofs(wr_addr, `SSCB_INT_CLEAR_OFS)) ?
		sscb_pkg::sscb_evt_s'(wr_data[2:0]) : 3'h0;

	// A new event beats a clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= 3'h0;
		end else begin
			status_q <= (status_q & ~clear_w) | evt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_q <= `SSCB_INT_ENABLE_RST;
		end else if (wr_req && is_ofs(wr_addr, `SSCB_INT_ENABLE_OFS) && wr_strb[0]) begin
			enable_q <= wr_data[2:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(((status_q & ~clear_w) | evt) & enable_q);
		end
	end

	// -----------------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic rd_sys_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_sys_q <= 1'b0;
		end else if (rd_req) begin
			rd_sys_q <= is_ofs(s_axil_araddr, `SSCB_SYSCTL_OFS);
		end
	end

	chk_term_drive: assert property (
		(ctl_q.reserved_terminal_drive && card32_present) |=> !rsvd_term_oe_n_q)
		else $error("reserved terminals not driven");
	chk_term_float: assert property (
		!ctl_q.reserved_terminal_drive |=> rsvd_term_oe_n_q)
		else $error("reserved terminals not floated");
	chk_reset_values: assert property (
		$rose(aresetn) |-> ctl_q.read_burst_toward_card && !ctl_q.read_burst_toward_host
		&& ctl_q.low_power_enable && ctl_q.id_write_lock && !ctl_q.supply_protect_disable)
		else $error("control reset values wrong");
	chk_burst_write: assert property (
		(wr_sys && wr_strb[1]) |=> ctl_q.read_burst_toward_card == $past(wr_data[15])
		&& ctl_q.read_burst_toward_host == $past(wr_data[14]))
		else $error("burst enables not written");
	chk_activity_set: assert property (
		card_access |=> activity_q)
		else $error("socket activity lost");
	chk_activity_clr: assert property (
		(rd_sys && !card_access) |=> !activity_q)
		else $error("socket activity not cleared by read");
	chk_fixed_bits: assert property (
		(s_axil_rvalid && rd_sys_q) |-> s_axil_rdata[12] && !s_axil_rdata[7])
		else $error("fixed bits read wrong");
	chk_stream_busy: assert property (
		(pwr_stream_active || up_busy) |=> stream_busy_q)
		else $error("power stream busy not shown");
	chk_up_settle: assert property (
		(pwr_sent_up && !ctx_clr) |=> up_busy)
		else $error("power-up settling not set");
	chk_down_settle: assert property (
		(pwr_sent_down && !ctx_clr) |=> down_busy)
		else $error("power-down settling not set");
	chk_interrog_flag: assert property (
		(!ctx_clr) |=> interrog_q == $past(interrogate_active))
		else $error("interrogation flag wrong");
	chk_ctx_clear: assert property (
		ctx_clr |=> !up_busy && !down_busy && !interrog_q)
		else $error("context bits not cleared");
	chk_ctx_keep: assert property (
		(pme_enable && interrogate_active) |=> interrog_q)
		else $error("context bit lost with events enabled");
	chk_bus_rst_keep: assert property (
		(!bus_reset_n && !wr_sys) |=> $stable(ctl_q))
		else $error("control bits changed by bus reset");

	cov_activity_read: cover property (card_access ##1 rd_sys ##1 !activity_q);
	cov_up_done: cover property ($fell(up_busy) ##1 !stream_busy_q);
	cov_irq: cover property ($rose(irq_q));
endmodule // sscb_ctrl

//--- test/sscb_ctrl_tb.sv
// Self-checking bench for the socket system control bank.
// Assumes the design files are compiled first and a 20 MHz aclk.
`timescale 1ns/1ps
module socket_system_control_bits_tb_top;
// ----------------------------------------------------------------------
// Design and stimulus
// ----------------------------------------------------------------------
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic bus_reset_n = 1'b1;
logic pme_enable = 1'b0;
logic [7:0] s_axil_awaddr = 8'h00;
logic [7:0] s_axil_araddr = 8'h00;
logic [31:0] s_axil_wdata = 32'h0;
logic [3:0] s_axil_wstrb = 4'hf;
logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
logic card_access = 1'b0, card32_present = 1'b1, pwr_stream_active = 1'b0;
logic pwr_sent_up = 1'b0, pwr_sent_down = 1'b0, interrogate_active = 1'b0;
logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
logic rsvd_term_out, rsvd_term_oe_n_q, irq_q;
logic [1:0] s_axil_bresp, s_axil_rresp, rr;
logic [31:0] s_axil_rdata, rv;
sscb_pkg::sscb_ctl_s ctl_q;
int mismatches = 0;
int n_tests = 0;
int cycles = 0;

always #25 aclk = ~aclk;

// Short settling delays keep the run brief.
sscb_ctrl #(.AW(8), .UP_DELAY_CYCLES(5), .DOWN_DELAY_CYCLES(8)) i_sscb_ctrl (
	.aclk(aclk), .aresetn(aresetn), .bus_reset_n(bus_reset_n), .pme_enable(pme_enable),
	.s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
	.s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
	.s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
	.s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
	.s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
	.s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
	.s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
	.s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
	.s_axil_rready(s_axil_rready), .card_access(card_access),
	.card32_present(card32_present), .pwr_stream_active(pwr_stream_active),
	.pwr_sent_up(pwr_sent_up), .pwr_sent_down(pwr_sent_down),
	.interrogate_active(interrogate_active), .ctl_q(ctl_q),
	.rsvd_term_out(rsvd_term_out), .rsvd_term_oe_n_q(rsvd_term_oe_n_q), .irq_q(irq_q)
);

// ----------------------------------------------------------------------
// Bus and check tasks
// ----------------------------------------------------------------------
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	n_tests++;
	if (g !== e) begin
		mismatches++;
		$display("[ERR] %s expected %h seen %h", nm, e, g);
	end
endtask

task automatic cyc(input int n);
	repeat (n) @(posedge aclk);
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
	logic ta, tw, ha, hw;
	ta = 1'b0;
	tw = 1'b0;
	@(posedge aclk);
	s_axil_awaddr <= a;
	s_axil_wdata <= d;
	s_axil_awvalid <= 1'b1;
	s_axil_wvalid <= 1'b1;
	s_axil_bready <= 1'b1;
	while (!(ta && tw)) begin
		@(negedge aclk);
		ha = !ta && s_axil_awready;
		hw = !tw && s_axil_wready;
		@(posedge aclk);
		if (ha) s_axil_awvalid <= 1'b0;
		if (hw) s_axil_wvalid <= 1'b0;
		ta = ta | ha;
		tw = tw | hw;
	end
	do @(negedge aclk); while (!s_axil_bvalid);
	rr = s_axil_bresp;
	@(posedge aclk);
	s_axil_bready <= 1'b0;
endtask

// With acc set, a card access lands in the very cycle the read is taken.
task automatic rd(input logic [7:0] a, input logic acc = 1'b0);
	@(posedge aclk);
	s_axil_araddr <= a;
	s_axil_arvalid <= 1'b1;
	s_axil_rready <= 1'b1;
	card_access <= acc;
	do @(negedge aclk); while (!s_axil_arready);
	@(posedge aclk);
	s_axil_arvalid <= 1'b0;
	card_access <= 1'b0;
	do @(negedge aclk); while (!s_axil_rvalid);
	rv = s_axil_rdata;
	rr = s_axil_rresp;
	@(posedge aclk);
	s_axil_rready <= 1'b0;
endtask

// ----------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------
task automatic t_reset;
	rd(8'h80);
	chk("sysctl reset", 32'h0044_9060, rv);
	chk("ctl reset", 32'h44b, {21'h0, ctl_q});
	chk("oe_n reset", 32'h0, {31'h0, rsvd_term_oe_n_q});
	chk("term level", 32'h0, {31'h0, rsvd_term_out});
endtask

task automatic t_pwr;
	pwr_stream_active <= 1'b1;
	cyc(2);
	rd(8'h80);
	chk("stream busy", 32'h4, {29'h0, rv[11:9]});
	pwr_stream_active <= 1'b0;
	pwr_sent_up <= 1'b1;
	cyc(1);
	pwr_sent_up <= 1'b0;
	rd(8'h80);
	chk("up settling", 32'h6, {29'h0, rv[11:9]});
	cyc(12);
	rd(8'h80);
	chk("up expired", 32'h0, {29'h0, rv[11:9]});
	pwr_sent_down <= 1'b1;
	cyc(1);
	pwr_sent_down <= 1'b0;
	rd(8'h80);
	chk("down settling", 32'h5, {29'h0, rv[11:9]});
	cyc(15);
	rd(8'h80);
	chk("down expired", 32'h0, {29'h0, rv[11:9]});
	rd(8'h90);
	chk("irq status", 32'h2, rv);
	chk("irq masked", 32'h0, {31'h0, irq_q});
	wr(8'h94, 32'h2);
	cyc(2);
	chk("irq raised", 32'h1, {31'h0, irq_q});
	wr(8'h98, 32'h2);
	cyc(2);
	chk("irq cleared", 32'h0, {31'h0, irq_q});
endtask

task automatic t_rw;
	wr(8'h80, 32'hffe4_ffff);
	chk("write resp", 32'h0, {30'h0, rr});
	rd(8'h80);
	chk("sysctl ones", 32'h0064_d060, rv);
	chk("oe_n drive", 32'h0, {31'h0, rsvd_term_oe_n_q});
	card32_present <= 1'b0;
	cyc(2);
	chk("oe_n absent", 32'h1, {31'h0, rsvd_term_oe_n_q});
	card32_present <= 1'b1;
	wr(8'h80, 32'h0004_0000);
	rd(8'h80);
	chk("sysctl zeros", 32'h0004_1000, rv);
	chk("oe_n float", 32'h1, {31'h0, rsvd_term_oe_n_q});
endtask

task automatic t_act;
	rd(8'h80, 1'b1);
	rd(8'h80);
	chk("activity kept", 32'h1, {31'h0, rv[13]});
	rd(8'h80);
	chk("activity cleared", 32'h0, {31'h0, rv[13]});
	interrogate_active <= 1'b1;
	cyc(2);
	rd(8'h80);
	chk("interrogating", 32'h1, {31'h0, rv[8]});
	interrogate_active <= 1'b0;
	cyc(2);
	rd(8'h80);
	chk("interrogation over", 32'h0, {31'h0, rv[8]});
endtask

// Bit 22 is zero here, so its default coming back would show a bus reset leak.
task automatic t_brst(input logic pme, input logic [31:0] e);
	pme_enable <= pme;
	pwr_sent_down <= 1'b1;
	cyc(1);
	pwr_sent_down <= 1'b0;
	bus_reset_n <= 1'b0;
	cyc(1);
	bus_reset_n <= 1'b1;
	rd(8'h80);
	chk("bus reset", e, rv & 32'h007f_c260);
	cyc(12);
endtask

// ----------------------------------------------------------------------
// Main sequence and closing
// ----------------------------------------------------------------------
task automatic stop_test;
	$display("comparisons %0d mismatches %0d", n_tests, mismatches);
	if (mismatches == 0 && n_tests > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask

always @(posedge aclk) begin
	cycles++;
	if (cycles == 4000) begin
		mismatches++;
		stop_test();
	end
end

initial begin
	cyc(5);
	aresetn <= 1'b1;
	t_reset();
	t_pwr();
	t_rw();
	t_act();
	t_brst(1'b1, 32'h0004_0200);
	t_brst(1'b0, 32'h0004_0000);
	wr(8'h80, 32'h0044_9060);
	wr(8'h44, 32'h0);
	chk("unmapped write", 32'h3, {30'h0, rr});
	rd(8'h40);
	chk("unmapped read", 32'h3, {30'h0, rr});
	stop_test();
end

endmodule // socket_system_control_bits_tb_top
